/* inc/tw_defs.vh */
// Constants shared by the two-wire memory target and its helpers
`ifndef TW_DEFS_VH
`define TW_DEFS_VH

// Device type nibble expected in the top of the device address word
`define TW_DEV_TYPE 4'ha
// Bit counter values: eight data bits, then the acknowledge clock
`define TW_CNT_DATA 4'h8
`define TW_CNT_ACK 4'h9
`define TW_CNT_ZERO 4'h0
// Write protection covers addresses with this bit set (upper half)
`define TW_PROT_BIT 7
// Reset values
`define TW_ADDR_RST 8'h00
`define TW_SYNC_RST 6'h3f
`define TW_BYTE_RST 8'h00
// Self-timed write cycle, in ns, and the clock period, in ns
`define TW_TWR_NS 5000000
`define TW_CLK_PERIOD_NS 4
`define TW_TWR_CYCLES (`TW_TWR_NS / `TW_CLK_PERIOD_NS)
// Write buffer shape: address byte above data byte
`define TW_FIFO_W 16
`define TW_FIFO_D 32
`define TW_FIFO_AW 5

`endif

/* rtl/tw_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "tw_defs.vh"

module tw_fifo #(
    parameter integer WIDTH = `TW_FIFO_W,
    parameter integer DEPTH = `TW_FIFO_D,
    parameter integer AW = `TW_FIFO_AW
) (
    input wire sys_clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] store_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] level_reg;
    wire push;
    wire pop;

    assign in_ready = (level_reg != DEPTH[AW:0]);
    assign out_valid = (level_reg != {(AW+1){1'b0}});
    assign out_data = store_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            store_reg[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            level_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                level_reg <= level_reg + 1'b1;
            end else if (pop && !push) begin
                level_reg <= level_reg - 1'b1;
            end
        end
    end

endmodule

/* rtl/tw_wr_timer.v */
// Self-timed nonvolatile write cycle timer
`timescale 1ns/1ps
`include "tw_defs.vh"

module tw_wr_timer #(
    parameter integer CYCLES = `TW_TWR_CYCLES
) (
    input wire sys_clk,
    input wire rst,
    input wire start,
    input wire hold,
    output reg busy
);

    reg [31:0] count_reg;

    // Busy lasts the full cycle time and also until the buffer has drained
    always @(posedge sys_clk) begin
        if (rst) begin
            busy <= 1'b0;
            count_reg <= 32'h0000_0000;
        end else if (start) begin
            busy <= 1'b1;
            count_reg <= 32'h0000_0000;
        end else if (busy) begin
            if (count_reg >= CYCLES - 1) begin
                if (!hold) begin
                    busy <= 1'b0;
                end
            end else begin
                count_reg <= count_reg + 32'h0000_0001;
            end
        end
    end

endmodule

/* rtl/tw_eeprom.v */
// Two-wire serial target and access sequencer of a 256-byte memory
// ======================================================================
// Overview of operation
// - Data changes only while clock is low; high-clock changes are start/stop.
// - Falling data with clock high is a start, detected in any state.
// - Rising data with clock high is a stop; ends reads into standby.
// - Words are eight bits, MSB first; device acks low on ninth clock.
// - Standby after power-up and after stop once internal work finishes.
// - First word after start is device address; top nibble must be 1010.
// - Next three bits must match the straps, else no ack and standby.
// - Address word LSB: one selects read, zero selects write.
// - Byte write: ack device address, word address, data; stop starts write.
// - During the write cycle every transfer goes unacknowledged.
// - Write cycle time runs from the ending stop to programming done.
// - Page write: up to 31 further bytes (32-entry buffer), each acked, ended by stop.
// - Write address advances in its low three bits, wrapping in page.
// - Polling: device address acked only once the write cycle ended.
// - Write protect high blocks writes to addresses 80h through FFh.
// - Address counter holds last accessed address plus one.
// - Read address wraps from the last byte to the first.
// - Current read: ack read address, send byte, controller nacks and stops.
// - Sequential read: each controller ack sends next byte; nack ends.
// - Write protect low leaves the whole array writable.
// - Array is 32 pages of eight bytes, 8-bit word address.
`timescale 1ns/1ps
`include "tw_defs.vh"

module tw_eeprom #(
    parameter integer TWR_CYCLES = `TW_TWR_CYCLES
) (
    input wire sys_clk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire strap_address_bit_2,
    input wire strap_address_bit_1,
    input wire strap_address_bit_0,
    input wire wp_in,
    output reg standby,
    output reg write_busy
);

    // ==================================================================
    // State encoding
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_DEV = 5'h02;
    localparam [4:0] ST_WORD = 5'h04;
    localparam [4:0] ST_WDAT = 5'h08;
    localparam [4:0] ST_RDAT = 5'h10;

    // Receiving states shift bits in and acknowledge each word
    function is_rx;
        input [4:0] st;
        begin
            is_rx = (st == ST_DEV) || (st == ST_WORD) || (st == ST_WDAT);
        end
    endfunction

    // ==================================================================
    // Input synchronisers
    wire [5:0] raw_in;
    reg [5:0] sync1_reg;
    reg [5:0] sync2_reg;
    reg scl_prev_reg;
    reg sda_prev_reg;
    wire scl_s;
    wire sda_s;
    wire wp_s;
    wire [2:0] strap_s;

    assign raw_in = {wp_in, strap_address_bit_2, strap_address_bit_1,
                     strap_address_bit_0, sda_in, scl_in};

    // Pins idle high, so the synchronisers start high to avoid a false edge
    localparam [5:0] SYNC_RST = `TW_SYNC_RST;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
            always @(posedge sys_clk) begin
                if (rst) begin
                    sync1_reg[gi] <= SYNC_RST[gi];
                    sync2_reg[gi] <= SYNC_RST[gi];
                end else begin
                    sync1_reg[gi] <= raw_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    assign scl_s = sync2_reg[0];
    assign sda_s = sync2_reg[1];
    assign strap_s = sync2_reg[4:2];
    assign wp_s = sync2_reg[5];

    always @(posedge sys_clk) begin
        if (rst) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    // ==================================================================
    // Bus events
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    // Data moving while the clock stays high marks a frame boundary
    assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // ==================================================================
    // Array, write buffer and write cycle timer
    reg [7:0] mem_reg [0:255];
    reg [4:0] state_reg;
    reg [3:0] cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] tx_reg;
    reg [7:0] addr_reg;
    reg rw_reg;
    reg mack_reg;
    reg wr_pend_reg;
    reg push_valid_reg;
    reg [15:0] push_data_reg;
    reg start_wr_reg;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire busy;
    wire dev_match;
    wire protected_byte;

    tw_fifo #(
        .WIDTH(`TW_FIFO_W),
        .DEPTH(`TW_FIFO_D),
        .AW(`TW_FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(push_valid_reg),
        .in_ready(fifo_in_ready),
        .in_data(push_data_reg),
        .out_valid(fifo_out_valid),
        .out_ready(busy),
        .out_data(fifo_out_data)
    );

    tw_wr_timer #(
        .CYCLES(TWR_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(start_wr_reg),
        .hold(fifo_out_valid),
        .busy(busy)
    );

    // Buffered bytes are programmed only inside the timed cycle
    always @(posedge sys_clk) begin
        if (fifo_out_valid && busy) begin
            mem_reg[fifo_out_data[15:8]] <= fifo_out_data[7:0];
        end
    end

    // No ack while the write cycle runs, which is also how polling works
    assign dev_match = (shift_reg[7:4] == `TW_DEV_TYPE)
                       && (shift_reg[3:1] == strap_s)
                       && !busy;

    assign protected_byte = wp_s && addr_reg[`TW_PROT_BIT];

    // ==================================================================
    // Protocol sequencer
    always @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= `TW_CNT_ZERO;
            shift_reg <= `TW_BYTE_RST;
            tx_reg <= `TW_BYTE_RST;
            addr_reg <= `TW_ADDR_RST;
            rw_reg <= 1'b0;
            mack_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            push_valid_reg <= 1'b0;
            push_data_reg <= 16'h0000;
            start_wr_reg <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            push_valid_reg <= 1'b0;
            start_wr_reg <= 1'b0;
            if (start_det) begin
                // A start aborts the transfer in progress, also after recovery; buffered write bytes and a running write cycle carry on
                state_reg <= ST_DEV;
                cnt_reg <= `TW_CNT_ZERO;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state_reg <= ST_IDLE;
                cnt_reg <= `TW_CNT_ZERO;
                sda_oe <= 1'b0;
                if (wr_pend_reg) begin
                    start_wr_reg <= 1'b1;
                    wr_pend_reg <= 1'b0;
                end
            end else if (scl_rise) begin
                if (state_reg != ST_IDLE && cnt_reg != `TW_CNT_ACK) begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
                if (is_rx(state_reg) && cnt_reg < `TW_CNT_DATA) begin
                    shift_reg <= {shift_reg[6:0], sda_s};
                end
                if (state_reg == ST_RDAT && cnt_reg == `TW_CNT_DATA) begin
                    mack_reg <= !sda_s;
                end
            end else if (scl_fall) begin
                case (state_reg)
                    ST_DEV: begin
                        if (cnt_reg == `TW_CNT_DATA) begin
                            if (dev_match) begin
                                sda_oe <= 1'b1;
                                rw_reg <= shift_reg[0];
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end else if (cnt_reg == `TW_CNT_ACK) begin
                            cnt_reg <= `TW_CNT_ZERO;
                            if (rw_reg) begin
                                state_reg <= ST_RDAT;
                                tx_reg <= mem_reg[addr_reg];
                                sda_oe <= !mem_reg[addr_reg][7];
                                addr_reg <= addr_reg + 8'h01;
                            end else begin
                                state_reg <= ST_WORD;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    ST_WORD: begin
                        if (cnt_reg == `TW_CNT_DATA) begin
                            sda_oe <= 1'b1;
                            addr_reg <= shift_reg;
                        end else if (cnt_reg == `TW_CNT_ACK) begin
                            sda_oe <= 1'b0;
                            cnt_reg <= `TW_CNT_ZERO;
                            state_reg <= ST_WDAT;
                        end
                    end
                    ST_WDAT: begin
                        if (cnt_reg == `TW_CNT_DATA) begin
                            // A full buffer refuses the byte rather than drop it
                            if (fifo_in_ready) begin
                                sda_oe <= 1'b1;
                                addr_reg <= {addr_reg[7:3],
                                             addr_reg[2:0] + 3'h1};
                                if (!protected_byte) begin
                                    push_valid_reg <= 1'b1;
                                    push_data_reg <= {addr_reg, shift_reg};
                                    wr_pend_reg <= 1'b1;
                                end
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end else if (cnt_reg == `TW_CNT_ACK) begin
                            sda_oe <= 1'b0;
                            cnt_reg <= `TW_CNT_ZERO;
                        end
                    end
                    ST_RDAT: begin
                        if (cnt_reg == `TW_CNT_ACK) begin
                            if (mack_reg) begin
                                cnt_reg <= `TW_CNT_ZERO;
                                tx_reg <= mem_reg[addr_reg];
                                sda_oe <= !mem_reg[addr_reg][7];
                                addr_reg <= addr_reg + 8'h01;
                            end else begin
                                state_reg <= ST_IDLE;
                                sda_oe <= 1'b0;
                            end
                        end else if (cnt_reg == `TW_CNT_DATA) begin
                            // Release so the controller can drive its ack
                            sda_oe <= 1'b0;
                        end else if (cnt_reg != `TW_CNT_ZERO) begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_oe <= !tx_reg[6];
                        end
                    end
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==================================================================
    // Registered status outputs
    always @(posedge sys_clk) begin
        if (rst) begin
            sda_out <= 1'b0;
            standby <= 1'b1;
            write_busy <= 1'b0;
        end else begin
            // Open drain: the pad only ever pulls low
            sda_out <= 1'b0;
            standby <= (state_reg == ST_IDLE) && !busy && !start_wr_reg;
            write_busy <= busy || start_wr_reg;
        end
    end

endmodule

/* tb/tw_eeprom_checker.sv */
// Port-level assertions for the two-wire memory target
`timescale 1ns/1ps
module tw_eeprom_checker #(
    parameter integer TWR_CYCLES = 50
) (
    input wire sys_clk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire strap_address_bit_2,
    input wire strap_address_bit_1,
    input wire strap_address_bit_0,
    input wire wp_in,
    input wire standby,
    input wire write_busy
);
    // ==========================================
    // Ages of raw pin events, saturating at 15
    logic [3:0] fall_age;
    logic [3:0] stop_age;
    logic [31:0] busy_len;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence start_seen;
        scl_in && $fell(sda_in);
    endsequence
    sequence stop_seen;
        scl_in && $rose(sda_in);
    endsequence
    always @(posedge sys_clk) begin
        if (rst) begin
            fall_age <= 4'hf;
            stop_age <= 4'hf;
        end else begin
            fall_age <= $fell(scl_in) ? 4'h0 : (fall_age == 4'hf ? fall_age : fall_age + 4'h1);
            stop_age <= $rose(sda_in) && scl_in ? 4'h0 :
                (stop_age == 4'hf ? stop_age : stop_age + 4'h1);
        end
        busy_len <= (write_busy && !rst) ? busy_len + 32'h0000_0001 : 32'h0000_0000;
    end
    // ==========================================
    // Assertions
    sda_out_zero_a: assert property (sda_out == 1'b0)
        else $error("data output value not zero");
    oe_after_fall_a: assert property ($rose(sda_oe) |-> fall_age inside {[1:8]})
        else $error("data line driven away from a clock fall");
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed while clock high");
    busy_quiet_a: assert property (write_busy |-> !sda_oe)
        else $error("acknowledge during write cycle");
    busy_not_idle_a: assert property (write_busy |-> !standby)
        else $error("standby during write cycle");
    busy_length_a: assert property ($fell(write_busy) |->
        busy_len >= TWR_CYCLES - 2 && busy_len <= TWR_CYCLES + 2)
        else $error("write cycle length wrong");
    busy_after_stop_a: assert property ($rose(write_busy) |-> stop_age <= 4'ha)
        else $error("write cycle began without a stop");
    start_wakes_a: assert property (start_seen |-> ##[1:8] !standby)
        else $error("start not detected");
    stop_settles_a: assert property (stop_seen |-> ##[1:8] (standby || write_busy))
        else $error("stop did not end the transfer");
    idle_quiet_a: assert property (standby |-> !sda_oe)
        else $error("data line driven in standby");
endmodule
bind tw_eeprom tw_eeprom_checker #(.TWR_CYCLES(TWR_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_address_bit_2(strap_address_bit_2),
    .strap_address_bit_1(strap_address_bit_1), .strap_address_bit_0(strap_address_bit_0),
    .wp_in(wp_in), .standby(standby), .write_busy(write_busy));

/* tb/tw_ctl_model.sv */
// Behavioural two-wire bus controller, 80 ns link clock
`timescale 1ns/1ps
module tw_ctl_model (
    input wire sys_clk,
    input wire sda_wire,
    output logic scl,
    output logic sda_low
);
    // ==========================================
    // Bus phases, clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Data moves mid low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        tick(5);
        sda_low <= ~b;
        tick(5);
        scl <= 1'b1;
        tick(5);
        r = sda_wire;
        tick(5);
        scl <= 1'b0;
    endtask
    task automatic start;
        sda_low <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(10);
        sda_low <= 1'b1;
        tick(10);
        scl <= 1'b0;
    endtask
    task automatic stop;
        sda_low <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(10);
        sda_low <= 1'b0;
        tick(10);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic get_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
    task automatic recover;
        logic r;
        start;
        repeat (9) bit_io(1'b1, r);
        start;
        stop;
    endtask
endmodule

/* tb/tb_tw_eeprom.sv */
// Self-checking bench for the two-wire memory target
`timescale 1ns/1ps
module tb_tw_eeprom;
    localparam logic [7:0] DEV_W = 8'haa;
    localparam logic [7:0] DEV_R = 8'hab;
    logic sys_clk;
    logic rst;
    logic wp_in;
    logic [2:0] strap;
    wire scl_in;
    wire sda_low;
    wire sda_out;
    wire sda_oe;
    wire standby;
    wire write_busy;
    // Pulled-up wire, low when either party drives
    wire sda_in = ~(sda_oe | sda_low);
    int fail_count;
    int total_checks;
    tw_eeprom #(.TWR_CYCLES(400)) dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .strap_address_bit_2(strap[2]),
        .strap_address_bit_1(strap[1]), .strap_address_bit_0(strap[0]), .wp_in(wp_in),
        .standby(standby), .write_busy(write_busy));
    tw_ctl_model ctl (.sys_clk(sys_clk), .sda_wire(sda_in), .scl(scl_in), .sda_low(sda_low));
    // ==========================================
    // Shared helpers
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic [7:0] d, input logic exp_ack);
        logic a;
        ctl.put_byte(d, a);
        chk("ack", {7'h00, a}, {7'h00, exp_ack});
    endtask
    task automatic rd(input logic nack, input logic [7:0] exp);
        logic [7:0] d;
        ctl.get_byte(nack, d);
        chk("read data", d, exp);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("busy end", {7'h00, write_busy}, 8'h00);
    endtask
    task automatic addr_set(input logic [7:0] a);
        ctl.start;
        wb(DEV_W, 1'b1);
        wb(a, 1'b1);
        ctl.start;
        wb(DEV_R, 1'b1);
    endtask
    function automatic logic [7:0] pg(input int a);
        return 8'h58 + 8'((a + 2) & 7);
    endfunction
    // ==========================================
    // Scenarios
    task automatic t_reset;
        chk("standby", {7'h00, standby}, 8'h01);
        chk("busy", {7'h00, write_busy}, 8'h00);
        chk("drive", {7'h00, sda_oe}, 8'h00);
    endtask
    task automatic t_bad_addr;
        logic [7:0] bad [3] = '{8'h3a, 8'ha8, 8'hae};
        foreach (bad[i]) begin
            ctl.start;
            wb(bad[i], 1'b0);
            ctl.stop;
            chk("standby", {7'h00, standby}, 8'h01);
        end
        // Moved straps must move the matching address with them
        strap <= 3'h3;
        ctl.start;
        wb(8'ha6, 1'b1);
        ctl.stop;
        ctl.start;
        wb(DEV_W, 1'b0);
        ctl.stop;
        strap <= 3'h5;
    endtask
    task automatic t_page_fill;
        ctl.start;
        wb(DEV_W, 1'b1);
        wb(8'h06, 1'b1);
        for (int k = 0; k < 32; k++) begin
            wb(8'h40 + 8'(k), 1'b1);
        end
        wb(8'h60, 1'b0);
        ctl.stop;
        chk("busy", {7'h00, write_busy}, 8'h01);
        ctl.start;
        wb(DEV_W, 1'b0);
        ctl.stop;
        wait_idle;
        ctl.start;
        wb(DEV_W, 1'b1);
        wb(8'h00, 1'b1);
        ctl.start;
        wb(DEV_R, 1'b1);
        for (int a = 0; a < 8; a++) begin
            rd(a == 7, pg(a));
        end
        ctl.stop;
    endtask
    task automatic t_wrap;
        ctl.start;
        wb(DEV_W, 1'b1);
        wb(8'hff, 1'b1);
        wb(8'ha5, 1'b1);
        ctl.stop;
        wait_idle;
        addr_set(8'hff);
        rd(1'b0, 8'ha5);
        rd(1'b1, pg(0));
        ctl.stop;
        chk("standby", {7'h00, standby}, 8'h01);
        ctl.start;
        wb(DEV_R, 1'b1);
        rd(1'b1, pg(1));
        ctl.stop;
    endtask
    task automatic t_protect;
        ctl.start;
        wb(DEV_W, 1'b1);
        wb(8'h80, 1'b1);
        wb(8'h3c, 1'b1);
        ctl.stop;
        wait_idle;
        wp_in <= 1'b1;
        ctl.start;
        wb(DEV_W, 1'b1);
        wb(8'h80, 1'b1);
        wb(8'hc3, 1'b1);
        ctl.stop;
        chk("busy", {7'h00, write_busy}, 8'h00);
        addr_set(8'h80);
        rd(1'b1, 8'h3c);
        ctl.stop;
        wp_in <= 1'b0;
    endtask
    task automatic t_recover;
        addr_set(8'h01);
        ctl.recover;
        chk("standby", {7'h00, standby}, 8'h01);
        ctl.start;
        wb(DEV_R, 1'b1);
        rd(1'b1, pg(2));
        ctl.stop;
    endtask
    // ==========================================
    // Clock, sequence, watchdog and verdict
    task automatic test_done;
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        wp_in = 1'b0;
        strap = 3'h5;
        fail_count = 0;
        total_checks = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (25) @(posedge sys_clk);
        t_reset;
        t_bad_addr;
        t_page_fill;
        t_wrap;
        t_protect;
        t_recover;
        test_done;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        test_done;
    end
endmodule
